/* rtl/fault_pkg.sv */
// Constants, types and register map shared by the fault response selector
// How it works
// (RULE1) Select bit picks register fields over strap
// (RULE2) Rail policy field bits 7:6, 11 equals 00
// (RULE3) Flag policy: set status bit, flag low
// (RULE4) Rail hiccup stops phases, restarts after 500ms
// (RULE5) Rail latch holds until enable toggled
// (RULE6) Flyback policy register layout, reset zero
// (RULE7) Flyback flag policy: status bit 4, flag
// (RULE8) Flyback hiccup: both stop, soft-start restart; code gives the soft-start pulse only while switching_en is high
// (RULE9) Flyback latch: chip enable toggle restarts
// (RULE10) Fault during restart wait restarts the timer
package fault_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] RESPONSE_SELECT_ADDR = 8'hB0;
    localparam logic [7:0] RAIL_POLICY_ADDR = 8'hB3;
    localparam logic [7:0] FLYBACK_POLICY_ADDR = 8'hB4;
    localparam logic [7:0] FAULT_STATUS_ADDR = 8'hD3;
    localparam logic [7:0] STATUS_CLEAR_ADDR = 8'hE0;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hE1;
    localparam logic [7:0] LIVE_STATE_ADDR = 8'hE2;

    // Field positions
    localparam int SELECT_BIT = 7;
    localparam int RAIL_UV_LSB = 6;
    localparam int FET_SHORT_BIT = 7;
    localparam int AVG_OC_LSB = 4;
    localparam int FLYBACK_OC_LSB = 0;
    localparam int STAT_RAIL_UV_BIT = 1;
    localparam int STAT_FLYBACK_OC_BIT = 4;
    localparam logic [7:0] FLYBACK_POLICY_MASK = 8'hB3;
    localparam logic [7:0] STATUS_MASK = 8'h12;

    // Reset values
    localparam logic [7:0] RESPONSE_SELECT_RST = 8'h00;
    localparam logic [7:0] RAIL_POLICY_RST = 8'h00;
    localparam logic [7:0] FLYBACK_POLICY_RST = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int HICCUP_MS = 500;
    localparam int HICCUP_CYCLES = (CLK_HZ / 1000) * HICCUP_MS;
    localparam int TIMER_W = 25;

    // Fault channels
    localparam int NUM_CH = 2;
    localparam int CH_RAIL = 0;
    localparam int CH_FLYBACK = 1;

    typedef enum logic [1:0] {
        POL_FLAG = 2'h0,
        POL_HICCUP = 2'h1,
        POL_LATCH = 2'h2,
        POL_FLAG_ALT = 2'h3
    } policy_t;

    // Gray order along run, hold, wait, latch; wait back to run flips both bits
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_HOLD = 2'h1,
        ST_WAIT = 2'h3,
        ST_LATCH = 2'h2
    } resp_state_t;

    typedef struct packed {
        logic rail_uv;
        logic flyback_oc;
        logic chip_en;
        logic switch_en;
        logic [1:0] mode;
    } pin_in_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

/* rtl/fault_response_selector.sv */
// Fault response selection for rail undervoltage and flyback overcurrent
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module fault_response_selector
    import fault_pkg::*;
#(
    parameter int RESTART_CYCLES = HICCUP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic housekeeping_rail_uv,
    input wire logic flyback_fet_oc,
    input wire logic chip_en,
    input wire logic switching_en,
    input wire logic [1:0] mode_strap,
    output logic fault_flag_n,
    output logic phase_drive_outputs_en,
    output logic flyback_drive_en,
    output logic soft_start_pulse,
    output logic irq
);

    // Reset release

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin inputs

    pin_in_t pins_raw;
    pin_in_t pins;

    assign pins_raw.rail_uv = housekeeping_rail_uv;
    assign pins_raw.flyback_oc = flyback_fet_oc;
    assign pins_raw.chip_en = chip_en;
    assign pins_raw.switch_en = switching_en;
    assign pins_raw.mode = mode_strap;

    pin_sync #(
        .WIDTH($bits(pin_in_t))
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // Enable toggles release a latched channel; either edge counts
    logic chip_en_d;
    logic switch_en_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_en_d <= 1'b0;
            switch_en_d <= 1'b0;
        end else begin
            chip_en_d <= pins.chip_en;
            switch_en_d <= pins.switch_en;
        end
    end

    wire chip_toggle = pins.chip_en ^ chip_en_d;
    wire switch_toggle = pins.switch_en ^ switch_en_d;

    // Register port

    reg_req_t req;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    logic [DATA_W-1:0] response_select;
    logic [DATA_W-1:0] rail_fault_policy;
    logic [DATA_W-1:0] flyback_current_fault_policy;
    logic [DATA_W-1:0] fault_status;
    logic [DATA_W-1:0] irq_enable;

    wire hit_select = (req.addr == RESPONSE_SELECT_ADDR);
    wire hit_rail = (req.addr == RAIL_POLICY_ADDR);
    wire hit_flyback = (req.addr == FLYBACK_POLICY_ADDR);
    wire hit_status = (req.addr == FAULT_STATUS_ADDR);
    wire hit_clear = (req.addr == STATUS_CLEAR_ADDR);
    wire hit_irq_en = (req.addr == IRQ_ENABLE_ADDR);
    wire hit_live = (req.addr == LIVE_STATE_ADDR);

    wire wr_select = req.wr && hit_select;
    wire wr_rail = req.wr && hit_rail;
    wire wr_flyback = req.wr && hit_flyback;
    wire wr_clear = req.wr && hit_clear;
    wire wr_irq_en = req.wr && hit_irq_en;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            response_select <= RESPONSE_SELECT_RST;
            rail_fault_policy <= RAIL_POLICY_RST; // RULE2
            flyback_current_fault_policy <= FLYBACK_POLICY_RST; // RULE6
            irq_enable <= IRQ_ENABLE_RST;
        end else begin
            if (wr_select) begin
                response_select <= req.wdata;
            end
            if (wr_rail) begin
                rail_fault_policy <= req.wdata;
            end
            if (wr_flyback) begin
                // Reserved bits 6 and 3:2 are not stored
                flyback_current_fault_policy <= req.wdata & FLYBACK_POLICY_MASK; // RULE6
            end
            if (wr_irq_en) begin
                irq_enable <= req.wdata & STATUS_MASK;
            end
        end
    end

    // Policy selection

    wire use_fields = response_select[SELECT_BIT];
    wire [1:0] rail_field = rail_fault_policy[RAIL_UV_LSB +: 2];
    wire [1:0] flyback_field = flyback_current_fault_policy[FLYBACK_OC_LSB +: 2];

    // Strap is read continuously, so a strap change acts like a field write
    wire [1:0] rail_code = use_fields ? rail_field : pins.mode; // RULE1
    wire [1:0] flyback_code = use_fields ? flyback_field : pins.mode; // RULE1

    policy_t policy [NUM_CH];

    assign policy[CH_RAIL] = policy_t'(rail_code); // RULE2
    assign policy[CH_FLYBACK] = policy_t'(flyback_code);

    // Per-channel fault inputs and release conditions

    logic [NUM_CH-1:0] fault_now;
    logic [NUM_CH-1:0] release_req;

    assign fault_now[CH_RAIL] = pins.rail_uv;
    assign fault_now[CH_FLYBACK] = pins.flyback_oc;
    assign release_req[CH_RAIL] = chip_toggle || switch_toggle; // RULE5
    // Flyback latch clears only on chip enable toggle
    assign release_req[CH_FLYBACK] = chip_toggle; // RULE9

    // Per-channel response machines

    resp_state_t state [NUM_CH];
    logic [NUM_CH-1:0] stopped;
    logic [NUM_CH-1:0] restarted;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            resp_state_t next_state;
            logic timer_done;
            wire is_hiccup = (policy[ch] == POL_HICCUP);
            wire is_latch = (policy[ch] == POL_LATCH);

            // Timer runs only while waiting with the fault removed
            hiccup_timer #(
                .CYCLES(RESTART_CYCLES)
            ) u_timer (
                .clk(clk),
                .rst_n(rst_n),
                .run(state[ch] == ST_WAIT && !fault_now[ch]),
                .done(timer_done)
            );

            always_comb begin
                next_state = state[ch];
                unique case (state[ch])
                    ST_RUN: begin
                        if (fault_now[ch] && is_hiccup) begin
                            next_state = ST_HOLD; // RULE4
                        end else if (fault_now[ch] && is_latch) begin
                            next_state = ST_LATCH; // RULE5
                        end
                    end
                    ST_HOLD: begin
                        if (!fault_now[ch]) begin
                            next_state = ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (fault_now[ch]) begin
                            next_state = ST_HOLD; // RULE10
                        end else if (timer_done) begin
                            next_state = ST_RUN; // RULE4
                        end
                    end
                    ST_LATCH: begin
                        // A toggle seen while the fault persists is ignored
                        if (release_req[ch] && !fault_now[ch]) begin
                            next_state = ST_RUN;
                        end
                    end
                endcase
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    state[ch] <= ST_RUN;
                end else begin
                    state[ch] <= next_state;
                end
            end

            assign stopped[ch] = (state[ch] != ST_RUN);
            assign restarted[ch] = (state[ch] == ST_WAIT) && (next_state == ST_RUN);
        end
    endgenerate

    // Status, clear and interrupt

    logic [DATA_W-1:0] status_set;
    logic [DATA_W-1:0] status_clr;

    always_comb begin
        status_set = '0;
        status_set[STAT_RAIL_UV_BIT] = fault_now[CH_RAIL]; // RULE3
        status_set[STAT_FLYBACK_OC_BIT] = fault_now[CH_FLYBACK]; // RULE7
    end

    assign status_clr = wr_clear ? (req.wdata & STATUS_MASK) : '0;

    // A fault in the clearing cycle keeps its bit set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_status <= '0;
        end else begin
            fault_status <= (fault_status & ~status_clr) | status_set; // RULE3 RULE7
        end
    end

    // Switching control

    wire phase_stop = stopped[CH_RAIL] || stopped[CH_FLYBACK]; // RULE4 RULE8
    wire flyback_stop = stopped[CH_FLYBACK]; // RULE8 RULE9
    wire next_flyback_en = pins.chip_en && !flyback_stop;
    // Phases also wait for the outside enable after a flyback restart
    wire next_phase_en = next_flyback_en && pins.switch_en && !phase_stop; // RULE9
    wire next_soft_start = restarted[CH_FLYBACK] && pins.switch_en; // RULE8

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_flag_n <= 1'b1;
            phase_drive_outputs_en <= 1'b0;
            flyback_drive_en <= 1'b0;
            soft_start_pulse <= 1'b0;
            irq <= 1'b0;
        end else begin
            fault_flag_n <= ~|fault_status; // RULE3 RULE7
            phase_drive_outputs_en <= next_phase_en;
            flyback_drive_en <= next_flyback_en;
            soft_start_pulse <= next_soft_start; // RULE8
            irq <= |(fault_status & irq_enable);
        end
    end

    // Read path

    logic [DATA_W-1:0] live_state;

    assign live_state = {2'h0, state[CH_FLYBACK], state[CH_RAIL], fault_now};

    logic [DATA_W-1:0] read_mux;

    always_comb begin
        read_mux = '0;
        if (hit_select) begin
            read_mux = response_select;
        end else if (hit_rail) begin
            read_mux = rail_fault_policy;
        end else if (hit_flyback) begin
            read_mux = flyback_current_fault_policy;
        end else if (hit_status) begin
            read_mux = fault_status;
        end else if (hit_irq_en) begin
            read_mux = irq_enable;
        end else if (hit_live) begin
            read_mux = live_state;
        end
    end

    // Clear register is write-only and reads as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule // fault_response_selector

/* rtl/hiccup_timer.sv */
// Restart delay counter for one hiccup channel
`timescale 1ns/1ps
module hiccup_timer
    import fault_pkg::*;
#(
    parameter int CYCLES = HICCUP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic done
);
    localparam logic [TIMER_W-1:0] LAST = TIMER_W'(CYCLES - 1);
    logic [TIMER_W-1:0] count;
    wire at_end = (count == LAST);

    // Dropping run clears the count, so a new fault restarts from zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!run || at_end) begin
            count <= '0; // RULE10
        end else begin
            count <= count + 1'b1;
        end
    end

    assign done = run && at_end; // RULE4
endmodule // hiccup_timer

/* rtl/pin_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pin_sync

/* verification/fault_response_selector_sva.sv */
// Port-level assertions for the fault response selector
`timescale 1ns/1ps
module fault_response_selector_sva
    import fault_pkg::*;
#(
    parameter int RESTART_CYCLES = HICCUP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic housekeeping_rail_uv,
    input wire logic flyback_fet_oc,
    input wire logic chip_en,
    input wire logic switching_en,
    input wire logic [1:0] mode_strap,
    input wire logic fault_flag_n,
    input wire logic phase_drive_outputs_en,
    input wire logic flyback_drive_en,
    input wire logic soft_start_pulse,
    input wire logic irq
);
    int rail_q;
    int fly_q;

    // Quiet time since each fault pin was last high; starts saturated so reset is not a fault
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rail_q <= RESTART_CYCLES;
            fly_q <= RESTART_CYCLES;
        end else begin
            rail_q <= housekeeping_rail_uv ? 0 : (rail_q < RESTART_CYCLES ? rail_q + 1 : rail_q);
            fly_q <= flyback_fet_oc ? 0 : (fly_q < RESTART_CYCLES ? fly_q + 1 : fly_q);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_RAIL_FLAG: assert property (housekeeping_rail_uv [*8] |-> ##[0:2] !fault_flag_n)
        else $error("rail fault not flagged");
    AST_FLY_FLAG: assert property (flyback_fet_oc [*8] |-> ##[0:2] !fault_flag_n)
        else $error("flyback fault not flagged");
    AST_FLAG_RELEASE: assert property ($rose(fault_flag_n) |-> $past(reg_wr, 1) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("flag released without clear");
    AST_IRQ_STATUS: assert property (irq |-> !fault_flag_n)
        else $error("irq without status");
    AST_CHIP_OFF: assert property (!chip_en [*6] |-> !flyback_drive_en && !phase_drive_outputs_en)
        else $error("drive with chip disabled");
    AST_SWITCH_OFF: assert property (!switching_en [*6] |-> !phase_drive_outputs_en)
        else $error("phase drive with switching disabled");
    AST_SS_PULSE: assert property (soft_start_pulse |=> !soft_start_pulse)
        else $error("soft start longer than one cycle");
    AST_SS_FLY: assert property (soft_start_pulse |-> ##[0:2] flyback_drive_en)
        else $error("soft start without flyback");
    AST_FLY_WAIT: assert property ($rose(flyback_drive_en) |-> fly_q >= RESTART_CYCLES)
        else $error("flyback restarted early");
    AST_RAIL_WAIT: assert property ($rose(phase_drive_outputs_en) |-> rail_q >= RESTART_CYCLES)
        else $error("phase restarted early");

    COV_SS: cover property (soft_start_pulse);
    COV_IRQ: cover property ($rose(irq));
    COV_PHASE_BACK: cover property ($rose(phase_drive_outputs_en));
endmodule // fault_response_selector_sva

bind fault_response_selector fault_response_selector_sva #(.RESTART_CYCLES(RESTART_CYCLES)) sva_i (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .housekeeping_rail_uv(housekeeping_rail_uv),
    .flyback_fet_oc(flyback_fet_oc), .chip_en(chip_en), .switching_en(switching_en),
    .mode_strap(mode_strap), .fault_flag_n(fault_flag_n),
    .phase_drive_outputs_en(phase_drive_outputs_en), .flyback_drive_en(flyback_drive_en),
    .soft_start_pulse(soft_start_pulse), .irq(irq)
);

/* verification/tb.sv */
// Directed register and fault-pin tests for the fault response selector
`timescale 1ns/1ps
module tb;
    import fault_pkg::*;
    // Short restart count keeps hiccup tests to tens of cycles
    localparam int RC = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic uv = 1'b0;
    logic oc = 1'b0;
    logic chip_en = 1'b1;
    logic sw_en = 1'b1;
    logic [1:0] mode = 2'h1;
    logic [7:0] reg_rdata;
    logic flag_n, ph_en, fly_en, ss, irq, seen;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    fault_response_selector #(.RESTART_CYCLES(RC)) dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .housekeeping_rail_uv(uv), .flyback_fet_oc(oc), .chip_en(chip_en),
        .switching_en(sw_en), .mode_strap(mode), .fault_flag_n(flag_n),
        .phase_drive_outputs_en(ph_en), .flyback_drive_en(fly_en),
        .soft_start_pulse(ss), .irq(irq)
    );

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask

    // Outputs are sampled at the falling edge, well clear of the launching edge
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("rdata", exp, reg_rdata);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_n(8);
        rd(8'hB0, 8'h00);
        rd(8'hB3, 8'h00);
        rd(8'hB4, 8'h00);
        rd(8'hE1, 8'h00);
        wr(8'hB4, 8'hFF);
        rd(8'hB4, 8'hB3);
        wr(8'hB4, 8'h00);
        wr(8'hB3, 8'hC5);
        rd(8'hB3, 8'hC5);
        wr(8'hB3, 8'hC0);
        rd(8'h55, 8'h00);
        wr(8'hD3, 8'hFF);
        rd(8'hD3, 8'h00);
        // Select clear: strap hiccup must win over field code 11
        @(posedge clk) uv <= 1'b1;
        wait_n(8);
        chk1("phase_en", 1'b0, ph_en);
        chk1("flag_n", 1'b0, flag_n);
        rd(8'hD3, 8'h02);
        @(posedge clk) uv <= 1'b0;
        wait_n(10);
        chk1("phase_en", 1'b0, ph_en);
        @(posedge clk) uv <= 1'b1;
        wait_n(6);
        @(posedge clk) uv <= 1'b0;
        wait_n(18);
        chk1("phase_en", 1'b0, ph_en);
        wait_n(15);
        chk1("phase_en", 1'b1, ph_en);
        wr(8'hE1, 8'h00);
        wait_n(2);
        chk1("irq", 1'b0, irq);
        wr(8'hE1, 8'h12);
        wait_n(2);
        chk1("irq", 1'b1, irq);
        wr(8'hE0, 8'h02);
        wait_n(3);
        chk1("irq", 1'b0, irq);
        chk1("flag_n", 1'b1, flag_n);
        // Select set, field code 11 behaves as flag only
        wr(8'hB0, 8'h80);
        @(posedge clk) uv <= 1'b1;
        wait_n(8);
        chk1("phase_en", 1'b1, ph_en);
        chk1("flag_n", 1'b0, flag_n);
        @(posedge clk) uv <= 1'b0;
        wait_n(4);
        wr(8'hE0, 8'h12);
        wr(8'hB3, 8'h80);
        @(posedge clk) uv <= 1'b1;
        wait_n(8);
        @(posedge clk) uv <= 1'b0;
        wait_n(40);
        chk1("phase_en", 1'b0, ph_en);
        rd(8'hE2, 8'h08);
        @(posedge clk) sw_en <= 1'b0;
        wait_n(6);
        @(posedge clk) sw_en <= 1'b1;
        wait_n(8);
        chk1("phase_en", 1'b1, ph_en);
        wr(8'hE0, 8'h12);
        for (int c = 0; c < 4; c += 3) begin
            wr(8'hB4, c[7:0]);
            @(posedge clk) oc <= 1'b1;
            wait_n(8);
            chk1("fly_en", 1'b1, fly_en);
            chk1("phase_en", 1'b1, ph_en);
            rd(8'hD3, 8'h10);
            @(posedge clk) oc <= 1'b0;
            wait_n(4);
            wr(8'hE0, 8'h12);
        end
        wr(8'hB4, 8'h01);
        @(posedge clk) oc <= 1'b1;
        wait_n(8);
        chk1("fly_en", 1'b0, fly_en);
        chk1("phase_en", 1'b0, ph_en);
        @(posedge clk) oc <= 1'b0;
        wait_n(10);
        chk1("fly_en", 1'b0, fly_en);
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(negedge clk);
            seen = (ss === 1'b1);
        end
        chk1("soft_start", 1'b1, seen);
        wait_n(5);
        chk1("phase_en", 1'b1, ph_en);
        wr(8'hB4, 8'h02);
        @(posedge clk) oc <= 1'b1;
        wait_n(8);
        @(posedge clk) oc <= 1'b0;
        wait_n(40);
        @(posedge clk) sw_en <= 1'b0;
        wait_n(6);
        @(posedge clk) sw_en <= 1'b1;
        wait_n(8);
        chk1("fly_en", 1'b0, fly_en);
        @(posedge clk) chip_en <= 1'b0;
        wait_n(6);
        @(posedge clk) chip_en <= 1'b1;
        wait_n(8);
        chk1("fly_en", 1'b1, fly_en);
        chk1("phase_en", 1'b1, ph_en);
        tally_and_finish();
    end
endmodule // tb
